// ===== rtl/pchr_pkg.sv
/*
  Package for the express capability header register bank.
  Assumes a 32-bit AHB-Lite register bus and byte addresses as printed.
*/
package pchr_pkg;
  localparam logic [11:0] HDR_OFFSET        = 12'h040;
  localparam logic [11:0] DCAP_OFFSET       = 12'h044;
  localparam logic [11:0] LOCK_OFFSET       = 12'h050;
  localparam logic [11:0] STATUS_OFFSET     = 12'h054;
  localparam logic [7:0]  CAP_ID_VALUE      = 8'h10;
  localparam logic [7:0]  NEXT_PTR_RESET    = 8'h00;
  localparam logic [3:0]  REVISION_RESET    = 4'h2;
  localparam logic [3:0]  TYPE_UPSTREAM     = 4'h5;
  localparam logic [3:0]  TYPE_DOWNSTREAM   = 4'h6;
  localparam logic        SLOT_RESET        = 1'b0;
  localparam logic [2:0]  PAYLOAD_RESET     = 3'h4;
  localparam logic [2:0]  PAYLOAD_MAX_CODE  = 3'h5;
  localparam logic        WIDE_TAG_RESET    = 1'b1;
  localparam logic        LOCK_RESET        = 1'b0;
  localparam int          CAP_ID_LSB        = 0;
  localparam int          NEXT_PTR_LSB      = 8;
  localparam int          REVISION_LSB      = 16;
  localparam int          PORT_TYPE_LSB     = 20;
  localparam int          SLOT_BIT          = 24;
  localparam int          MSG_INDEX_LSB     = 25;
  localparam int          PAYLOAD_LSB       = 0;
  localparam int          WIDE_TAG_BIT      = 5;
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
  localparam logic [2:0]  HSIZE_WORD        = 3'h2;
endpackage

// ===== rtl/pchr_payload_decode.sv
/*
  Decodes the payload capability code into an effective code and byte size.
  Assumes a plain three-bit code input.
*/
`timescale 1ns/100ps
`default_nettype none
module pchr_payload_decode (
  input  wire logic [2:0]  code,
  output logic      [2:0]  effective_code,
  output logic      [12:0] payload_bytes
);
  // Reserved codes act as 128 bytes
  assign effective_code = (code > pchr_pkg::PAYLOAD_MAX_CODE) ? 3'h0 : code;
  // 128 shifted by the effective code
  assign payload_bytes  = 13'(13'h0080 << effective_code);
endmodule
`default_nettype wire

// ===== rtl/pchr_regs.sv
/*
  Express capability header and device capabilities registers on AHB-Lite.
  Assumes one AHB-Lite master, single word transfers, synchronous inputs.
*/
// Local design decision: the AHB-Lite register port.
// Operation
// - Header low byte reads fixed 0x10
// - Bits 15:8 lockable next structure pointer
// - Bits 19:16 lockable revision, default 0x2
// - Port type 0x5 upstream, 0x6 downstream
// - Lockable slot bit, reset zero, writable for both port types
// - Message interrupt index reads zero
// - Lockable payload capability, default 0x4
// - Codes 0x6, 0x7 act as 128 bytes
// - Borrowed function bits read zero
// - Lockable wide tag bit, default one
// - Standby exit latency reads zero
// - Sleep exit latency reads zero
// - Button fitted bit reads zero
// - Lamp fitted bit reads zero
`timescale 1ns/100ps
`default_nettype none
module pchr_regs #(
  parameter logic [7:0] NEXT_PTR_DEFAULT = pchr_pkg::NEXT_PTR_RESET
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        is_upstream,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [2:0]  effective_payload_code,
  output logic      [12:0] payload_bytes
);
  logic [7:0]  next_ptr_ff;
  logic [3:0]  revision_ff;
  logic        slot_ff;
  logic [2:0]  payload_ff;
  logic        wide_tag_ff;
  logic        lock_open_ff;
  logic        wr_pend_ff;
  logic [11:0] wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic        nxt_wr_pend;
  logic [31:0] nxt_hrdata;
  wire         access_ok;
  wire         rd_req;
  wire  [31:0] hdr_word;
  wire  [31:0] dcap_word;
  wire  [31:0] status_word;
  wire         wr_hdr;
  wire         wr_dcap;
  wire         wr_lock;
  wire  [3:0]  port_type;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a[11:2] == off[11:2]);
  endfunction

  assign access_ok = hsel && hready && (htrans == pchr_pkg::HTRANS_NONSEQ)
                     && (hsize == pchr_pkg::HSIZE_WORD);
  assign rd_req    = access_ok && !hwrite;
  assign nxt_wr_pend = access_ok && hwrite;
  assign port_type = is_upstream ? pchr_pkg::TYPE_UPSTREAM
                                 : pchr_pkg::TYPE_DOWNSTREAM;

  // Fixed ID 0x10 and port type fields; reserved and message interrupt index bits read zero
  assign hdr_word = {2'b00, 5'h00, slot_ff, port_type, revision_ff, next_ptr_ff,
                     pchr_pkg::CAP_ID_VALUE};
  // Hardwired zero fields
  assign dcap_word = {18'h00000, 1'b0, 1'b0, 3'h0, 3'h0, wide_tag_ff, 2'h0,
                      payload_ff};
  assign status_word = {16'h0000, payload_bytes[12:0], effective_payload_code};

  assign nxt_hrdata = !rd_req ? hrdata_ff
                    : addr_is(haddr, pchr_pkg::HDR_OFFSET)    ? hdr_word
                    : addr_is(haddr, pchr_pkg::DCAP_OFFSET)   ? dcap_word
                    : addr_is(haddr, pchr_pkg::LOCK_OFFSET)   ? {31'h0, lock_open_ff}
                    : addr_is(haddr, pchr_pkg::STATUS_OFFSET) ? status_word
                    : 32'h0000_0000;

  // Writable fields except the lock bit move only while the lock is open
  assign wr_hdr  = wr_pend_ff && lock_open_ff && addr_is(wr_addr_ff, pchr_pkg::HDR_OFFSET);
  assign wr_dcap = wr_pend_ff && lock_open_ff && addr_is(wr_addr_ff, pchr_pkg::DCAP_OFFSET);
  assign wr_lock = wr_pend_ff && addr_is(wr_addr_ff, pchr_pkg::LOCK_OFFSET);

  pchr_payload_decode u_decode (
    .code           (payload_ff),
    .effective_code (effective_payload_code),
    .payload_bytes  (payload_bytes)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hrdata_ff  <= 32'h0000_0000;
    end else if (clk_en) begin
      wr_pend_ff <= nxt_wr_pend;
      if (nxt_wr_pend) begin
        wr_addr_ff <= haddr;
      end
      hrdata_ff  <= nxt_hrdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      next_ptr_ff  <= NEXT_PTR_DEFAULT;
      revision_ff  <= pchr_pkg::REVISION_RESET;
      slot_ff      <= pchr_pkg::SLOT_RESET;
      payload_ff   <= pchr_pkg::PAYLOAD_RESET;
      wide_tag_ff  <= pchr_pkg::WIDE_TAG_RESET;
      lock_open_ff <= pchr_pkg::LOCK_RESET;
    end else if (clk_en) begin
      if (wr_lock) begin
        lock_open_ff <= hwdata[0];
      end
      if (wr_hdr) begin
        next_ptr_ff <= hwdata[pchr_pkg::NEXT_PTR_LSB +: 8];
        revision_ff <= hwdata[pchr_pkg::REVISION_LSB +: 4];
        slot_ff     <= hwdata[pchr_pkg::SLOT_BIT];
      end
      if (wr_dcap) begin
        payload_ff  <= hwdata[pchr_pkg::PAYLOAD_LSB +: 3];
        wide_tag_ff <= hwdata[pchr_pkg::WIDE_TAG_BIT];
      end
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
endmodule
`default_nettype wire

// ===== sim/pchr_regs_props.sv
/* Assertions on the pchr_regs ports.
   Assumes a bind to every pchr_regs instance. */
`timescale 1ns/100ps
`default_nettype none
module pchr_regs_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        clk_en,
  input wire logic        is_upstream,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [2:0]  effective_payload_code,
  input wire logic [12:0] payload_bytes
);
  wire rd = hsel && hready && htrans == 2'h2 && !hwrite && hsize == 3'h2 && clk_en;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd(a); rd && haddr == a; endsequence
  property p_id; s_rd(12'h040) |=> hrdata[7:0] == 8'h10; endproperty
  a_id: assert property (p_id) else $error("id");
  property p_ty; s_rd(12'h040) |=> hrdata[23:20] == ($past(is_upstream) ? 4'h5 : 4'h6); endproperty
  a_ty: assert property (p_ty) else $error("type");
  property p_hz; s_rd(12'h040) |=> hrdata[31:25] == 7'h00; endproperty
  a_hz: assert property (p_hz) else $error("hdr zero");
  property p_dz; s_rd(12'h044) |=> hrdata[4:3] == 2'h0 && hrdata[13:6] == 8'h00; endproperty
  a_dz: assert property (p_dz) else $error("dcap zero");
  property p_ef; effective_payload_code <= 3'h5 && payload_bytes == 13'h0080 << effective_payload_code; endproperty
  a_ef: assert property (p_ef) else $error("payload");
  property p_st; s_rd(12'h054) |=> hrdata[15:0] == {$past(payload_bytes), $past(effective_payload_code)}; endproperty
  a_st: assert property (p_st) else $error("status");
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("resp");
  property p_hd; !rd |=> $stable(hrdata); endproperty
  a_hd: assert property (p_hd) else $error("hold");
endmodule
bind pchr_regs pchr_regs_props u_props (.hclk, .hresetn, .clk_en, .is_upstream, .hsel, .haddr,
  .htrans, .hwrite, .hsize, .hready, .hrdata, .hreadyout, .hresp, .effective_payload_code,
  .payload_bytes);
`default_nettype wire

// ===== sim/pchr_regs_tb.sv
/* Self-checking bench for pchr_regs.
   Assumes the bench is the only AHB-Lite master. */
`timescale 1ns/100ps
`default_nettype none
module pchr_regs_tb;
  logic hclk = 0, hresetn = 0, is_upstream = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, hrdata, q, d;
  logic [2:0] eff, hsz = 3'h2;
  logic ce = 1'b1;
  logic [12:0] pb;
  int bad_count = 0, samples_checked = 0, seed = 96157, cyc = 0;
  always #20 hclk = ~hclk;
  pchr_regs dut (.hclk, .hresetn, .clk_en(ce), .is_upstream, .hsel, .haddr, .htrans, .hwrite,
    .hsize(hsz), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .effective_payload_code(eff), .payload_bytes(pb));
  function automatic logic [31:0] hdr(logic [31:0] v, logic up);
    return {7'h00, v[24], up ? 4'h5 : 4'h6, v[19:8], 8'h10};
  endfunction
  function automatic logic [2:0] ec(logic [2:0] c);
    return c > 3'h5 ? 3'h0 : c;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] v);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (12) @(posedge hclk);
    chk("eff_rst", 32'h4, {29'h0, eff});
    hresetn <= 1'b1;
    for (int up = 0; up < 2; up++) begin
      is_upstream <= up[0];
      xfer(1'b0, 12'h040, 32'h0);
      chk("hdr_rst", hdr(32'h00020000, up[0]), q);
    end
    xfer(1'b0, 12'h044, 32'h0);
    chk("dcap_rst", 32'h24, q);
    xfer(1'b1, 12'h044, 32'h0);
    xfer(1'b1, 12'h040, 32'hFFFFFFFF);
    xfer(1'b0, 12'h044, 32'h0);
    chk("dcap_lock", 32'h24, q);
    xfer(1'b0, 12'h040, 32'h0);
    chk("hdr_lock", hdr(32'h00020000, 1'b1), q);
    $display("reset and lock test done");
    xfer(1'b1, 12'h050, 32'h1);
    repeat (6) begin
      d = $random(seed);
      is_upstream <= d[31];
      d[24] = d[24] & ~d[31];
      xfer(1'b1, 12'h040, d);
      xfer(1'b0, 12'h040, 32'h0);
      chk("hdr_wr", hdr(d, d[31]), q);
    end
    for (int c = 0; c < 8; c++) begin
      d = $random(seed);
      d[2:0] = c[2:0];
      xfer(1'b1, 12'h044, d);
      xfer(1'b0, 12'h044, 32'h0);
      chk("dcap_wr", {26'h0, d[5], 2'h0, d[2:0]}, q);
      chk("eff", {29'h0, ec(c[2:0])}, {29'h0, eff});
      chk("bytes", {19'h0, 13'h0080 << ec(c[2:0])}, {19'h0, pb});
    end
    xfer(1'b0, 12'h054, 32'h0);
    chk("status", 32'h400, {16'h0, q[15:0]});
    xfer(1'b0, 12'h0F0, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("write and decode test done");
    hsz <= 3'h0;
    xfer(1'b1, 12'h044, 32'h0);
    hsz <= 3'h2;
    xfer(1'b0, 12'h044, 32'h0);
    chk("size_ignored", {26'h0, d[5], 2'h0, 3'h7}, q);
    ce <= 1'b0;
    xfer(1'b1, 12'h044, 32'h0);
    ce <= 1'b1;
    xfer(1'b0, 12'h044, 32'h0);
    chk("enable_frozen", {26'h0, d[5], 2'h0, 3'h7}, q);
    $display("size and enable test done");
    end_of_test();
  end
endmodule
`default_nettype wire
